// file: design/ctsp_pkg.sv
// Operation
// - Device drives one stream clock shared by every lane.
// - Device drives one active-low stream reset common to all lanes.
// - Each lane word goes onto its serial lane lowest byte first.
// - Device drives ready to show when a transmit word is taken.
// - Frame marker names frame-start byte positions of the next cycle's word.
// - Marker 0001 means the frame starts in byte 0.
// - Marker 0010 means frame starts in byte 1, byte 0 ends previous.
// - Marker 0100 means frame starts in byte 2, bytes 0-1 end previous.
// - Marker 1000 means frame starts in byte 3, bytes 0-2 end previous.
// - Several marker bits set when frames are shorter than a word.
// - Multiframe marker uses the same encoding and the same one-cycle lead.
// - The single marker pair applies to every lane slice alike.
// - In subclass 1 the timing reference input is required and used.
// - Once sync request rises, send lane alignment sequence, then user data.
package ctsp_pkg;

  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          RST_HOLD_NS     = 64;
  localparam int          RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SYNC_STAGES     = 3;
  localparam int          ILA_MULTIFRAMES = 4;
  localparam int          BYTES_PER_WORD  = 4;
  localparam int          OCT_W           = 16;

  localparam logic [7:0]  CHAR_COMMA      = 8'hBC;
  localparam logic [7:0]  CHAR_MF_START   = 8'h1C;
  localparam logic [7:0]  CHAR_MF_END     = 8'h7C;
  localparam logic [7:0]  CHAR_FILL       = 8'h00;

  typedef enum logic [1:0] {
    ST_ALIGN,
    ST_ILA,
    ST_DATA
  } ctsp_state_t;

  typedef struct packed {
    logic [3:0] multiframe_begin_marker;
    logic [3:0] frame_begin_marker;
  } ctsp_marker_t;

endpackage : ctsp_pkg

// file: design/ctsp_pin_sync.sv
`timescale 1ns/1ns
module ctsp_pin_sync
  import ctsp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level_q
);

  logic [SYNC_STAGES-1:0] stage_q;

  // First stage feeds only the second; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= '0;
      level_q <= 1'b0;
    end else begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], pin};
      if (stage_q[1] == stage_q[2]) begin
        level_q <= stage_q[2];
      end
    end
  end

endmodule : ctsp_pin_sync

// file: design/ctsp_tx_port.sv
`timescale 1ns/1ns
module ctsp_tx_port
  import ctsp_pkg::*;
#(
  parameter int LANES           = 4,
  parameter int OCTETS_PER_FRM  = 8,
  parameter int FRMS_PER_MF     = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  subclass1,
  input  wire logic [32*LANES-1:0]   tx_data,
  input  wire logic                  sysref,
  input  wire logic                  sync_req_n,
  output logic                       stream_clk_q,
  output logic                       stream_reset_n_q,
  output logic                       ready_q,
  output ctsp_marker_t               tx_marker_q,
  output logic [8*LANES-1:0]         lane_byte_q,
  output logic [LANES-1:0]           lane_ctrl_q
);

  localparam int MF_OCTETS = OCTETS_PER_FRM * FRMS_PER_MF;

  // Marks byte positions of a word whose first octet sits at base
  function automatic logic [3:0] start_mask(input int unsigned base, input int unsigned period);
    logic [3:0] m;
    m = '0;
    for (int i = 0; i < BYTES_PER_WORD; i++) begin
      m[i] = (((base + i) % period) == 0);
    end
    return m;
  endfunction : start_mask

  ctsp_state_t            st_q;
  ctsp_state_t            st_d;
  logic [OCT_W-1:0]       oct_q;
  logic [OCT_W-1:0]       oct_d;
  logic [7:0]             rst_cnt_q;
  logic [1:0]             ila_cnt_q;
  logic                   lmfc_ok_q;
  logic                   sref_prev_q;
  logic [32*LANES-1:0]    word_q;
  logic                   sync_ok;
  logic                   sref_lvl;

  ctsp_pin_sync u_sync_req (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin     (sync_req_n),
    .level_q (sync_ok)
  );

  ctsp_pin_sync u_sysref (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin     (sysref),
    .level_q (sref_lvl)
  );

  wire        ph0       = (oct_q[1:0] == 2'h0);
  wire        mf_last   = (oct_q == OCT_W'(MF_OCTETS - 1));
  wire        mf_tail   = (oct_q >= OCT_W'(MF_OCTETS - BYTES_PER_WORD));
  wire        sref_edge = sref_lvl && !sref_prev_q;
  // Realignment only while idle; moving the multiframe mid-data would tear frames
  wire        realign   = subclass1 && sref_edge && (st_q == ST_ALIGN);
  wire        ila_last  = (ila_cnt_q == 2'(ILA_MULTIFRAMES - 1));
  wire        next_data = sync_ok && ((st_q == ST_DATA) || ((st_q == ST_ILA) && ila_last && mf_tail));
  wire        ready_d   = next_data && (oct_q[1:0] == 2'h3);
  wire [OCT_W-1:0] nxt_base = oct_q + OCT_W'(2);
  // Marker leads the word by one cycle: computed two octets ahead, then registered
  wire [3:0]  fr_mask   = start_mask(32'(nxt_base), OCTETS_PER_FRM);
  wire [3:0]  mf_mask   = start_mask(32'(nxt_base), MF_OCTETS);
  wire        mark_en   = next_data && (oct_q[1:0] == 2'h2);

  assign oct_d = (realign || mf_last) ? '0 : oct_q + OCT_W'(1);

  always_comb begin
    st_d = st_q;
    if (!sync_ok || !stream_reset_n_q) begin
      st_d = ST_ALIGN;
    end else if (mf_last) begin
      unique case (st_q)
        ST_ALIGN: if (lmfc_ok_q || !subclass1) st_d = ST_ILA;
        ST_ILA:   if (ila_last) st_d = ST_DATA;
        ST_DATA:  st_d = ST_DATA;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stream_clk_q     <= 1'b0;
      stream_reset_n_q <= 1'b0;
      rst_cnt_q        <= '0;
      st_q             <= ST_ALIGN;
      oct_q            <= '0;
      ila_cnt_q        <= '0;
      lmfc_ok_q        <= 1'b0;
      sref_prev_q      <= 1'b0;
      ready_q          <= 1'b0;
      tx_marker_q      <= '0;
    end else begin
      stream_clk_q     <= !stream_clk_q;
      if (rst_cnt_q != 8'(RST_HOLD_CYC)) begin
        rst_cnt_q <= rst_cnt_q + 8'h01;
      end
      stream_reset_n_q <= (rst_cnt_q == 8'(RST_HOLD_CYC));
      st_q             <= st_d;
      oct_q            <= oct_d;
      sref_prev_q      <= sref_lvl;
      if (realign) begin
        lmfc_ok_q <= 1'b1;
      end
      if (st_q != ST_ILA) begin
        ila_cnt_q <= '0;
      end else if (mf_last) begin
        ila_cnt_q <= ila_cnt_q + 2'h1;
      end
      ready_q          <= ready_d;
      tx_marker_q      <= mark_en ? ctsp_marker_t'{mf_mask, fr_mask} : '0;
    end
  end

  // Serialiser: word held after the ready cycle, bytes sent lowest first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_q      <= '0;
      lane_byte_q <= '0;
      lane_ctrl_q <= '0;
    end else begin
      if (ready_q) begin
        word_q <= tx_data;
      end
      for (int n = 0; n < LANES; n++) begin
        if (st_q == ST_DATA) begin
          lane_byte_q[8*n +: 8] <= ready_q ? tx_data[32*n +: 8] : word_q[32*n + 8*oct_q[1:0] +: 8];
          lane_ctrl_q[n]        <= 1'b0;
        end else if (st_q == ST_ILA) begin
          lane_byte_q[8*n +: 8] <= (oct_q == '0) ? CHAR_MF_START : (mf_last ? CHAR_MF_END : CHAR_FILL);
          lane_ctrl_q[n]        <= (oct_q == '0) || mf_last;
        end else begin
          lane_byte_q[8*n +: 8] <= CHAR_COMMA;
          lane_ctrl_q[n]        <= 1'b1;
        end
      end
    end
  end

  property p_ready_phase;
    @(posedge mclk) disable iff (!reset_n) ready_q |-> (st_q == ST_DATA) && ph0;
  endproperty
  a_ready_phase: assert property (p_ready_phase) else $error("ready off word boundary");

  property p_ready_spacing;
    @(posedge mclk) disable iff (!reset_n) ready_q |=> !ready_q [*3];
  endproperty
  a_ready_spacing: assert property (p_ready_spacing) else $error("ready too frequent");

  property p_marker_lead;
    @(posedge mclk) disable iff (!reset_n)
      (tx_marker_q.frame_begin_marker != 4'h0) && sync_ok |=> ready_q;
  endproperty
  a_marker_lead: assert property (p_marker_lead) else $error("marker not one cycle before data");

  property p_mf_in_frame;
    @(posedge mclk) disable iff (!reset_n)
      (tx_marker_q.multiframe_begin_marker & ~tx_marker_q.frame_begin_marker) == 4'h0;
  endproperty
  a_mf_in_frame: assert property (p_mf_in_frame) else $error("multiframe start not a frame start");

  property p_byte_first;
    @(posedge mclk) disable iff (!reset_n)
      ready_q && sync_ok |=> lane_byte_q[7:0] == $past(tx_data[7:0]);
  endproperty
  a_byte_first: assert property (p_byte_first) else $error("lowest byte not sent first");

  property p_byte_last;
    @(posedge mclk) disable iff (!reset_n)
      ready_q && sync_ok ##1 sync_ok [*3] |=> lane_byte_q[7:0] == $past(tx_data[31:24], 4);
  endproperty
  a_byte_last: assert property (p_byte_last) else $error("top byte not sent last");

  property p_no_ready_in_reset;
    @(posedge mclk) disable iff (!reset_n) !stream_reset_n_q |-> !ready_q && (st_q == ST_ALIGN);
  endproperty
  a_no_ready_in_reset: assert property (p_no_ready_in_reset) else $error("data taken during stream reset");

  property p_sref_needed;
    @(posedge mclk) disable iff (!reset_n)
      subclass1 && (st_q == ST_ALIGN) ##1 (st_q == ST_ILA) |-> lmfc_ok_q;
  endproperty
  a_sref_needed: assert property (p_sref_needed) else $error("alignment left without timing reference");

  property p_ila_before_data;
    @(posedge mclk) disable iff (!reset_n)
      (st_q != ST_DATA) ##1 (st_q == ST_DATA) |-> $past(st_q) == ST_ILA && $past(sync_ok) && oct_q == '0;
  endproperty
  a_ila_before_data: assert property (p_ila_before_data) else $error("data without lane alignment");

  property p_drop_on_sync;
    @(posedge mclk) disable iff (!reset_n)
      !sync_ok |=> (st_q == ST_ALIGN) ##1 (lane_ctrl_q == {LANES{1'b1}}) && (lane_byte_q[7:0] == CHAR_COMMA);
  endproperty
  a_drop_on_sync: assert property (p_drop_on_sync) else $error("sync request low not honoured");

  property p_clk_toggle;
    @(posedge mclk) disable iff (!reset_n)
      stream_reset_n_q |=> stream_clk_q != $past(stream_clk_q);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("stream clock stalled");

  property p_reset_count;
    @(posedge mclk) disable iff (!reset_n)
      $rose(stream_reset_n_q) |-> (rst_cnt_q == 8'(RST_HOLD_CYC));
  endproperty
  a_reset_count: assert property (p_reset_count) else $error("stream reset released early");

  property p_marker_quiet;
    @(posedge mclk) disable iff (!reset_n)
      !next_data |=> (tx_marker_q == '0);
  endproperty
  a_marker_quiet: assert property (p_marker_quiet) else $error("marker without following data word");

  property p_ila_start;
    @(posedge mclk) disable iff (!reset_n)
      (st_q == ST_ILA) && (oct_q == '0) |=> (lane_byte_q[7:0] == CHAR_MF_START) && lane_ctrl_q[0];
  endproperty
  a_ila_start: assert property (p_ila_start) else $error("alignment sequence not opened");

endmodule : ctsp_tx_port

// file: bench/ctsp_src_model.sv
`timescale 1ns/1ns
module ctsp_src_model
  import ctsp_pkg::*;
#(
  parameter int LANES = 2
) (
  input  wire logic             mclk,
  input  wire logic             stream_reset_n,
  input  wire logic             ready,
  output logic [32*LANES-1:0]   tx_data
);
  logic [7:0] seq_q;
  // No valid qualifier, so the next word must already stand when ready ends
  always_ff @(posedge mclk or negedge stream_reset_n) begin
    if (!stream_reset_n) begin
      seq_q <= 8'h00;
    end else if (ready) begin
      seq_q <= seq_q + 8'h01;
    end
  end
  // Each byte carries sequence, lane and position, so any reorder shows up
  always_comb begin
    for (int n = 0; n < LANES; n++) begin
      for (int b = 0; b < 4; b++) begin
        tx_data[32*n+8*b +: 8] = {seq_q[3:0], 2'(n), 2'(b)};
      end
    end
  end
endmodule : ctsp_src_model

// file: bench/tb_ctsp_tx_port.sv
`timescale 1ns/1ns
module tb_ctsp_tx_port
  import ctsp_pkg::*;
;
  localparam int    LN = 2;
  logic             mclk, reset_n, sync_req_n, sysref, sc1, s_clk, s_rst_n, ready, ready2, seen, r2;
  logic [32*LN-1:0] tx_data;
  ctsp_marker_t     mk, mk2, pmk, pmk2;
  logic [8*LN-1:0]  lb;
  logic [LN-1:0]    lc;
  logic [63:0]      w;
  logic [7:0]       rows [4] = '{8'h11, 8'h01, 8'h11, 8'h01};
  int               mismatches, checked, n;

  ctsp_tx_port #(.LANES(LN), .OCTETS_PER_FRM(4), .FRMS_PER_MF(2)) i_ctsp_tx_port (
    .mclk, .reset_n, .subclass1(1'b0), .tx_data, .sysref, .sync_req_n, .stream_clk_q(s_clk),
    .stream_reset_n_q(s_rst_n), .ready_q(ready), .tx_marker_q(mk), .lane_byte_q(lb), .lane_ctrl_q(lc));
  // One-octet frames: every word boundary holds four frame starts
  ctsp_tx_port #(.LANES(LN), .OCTETS_PER_FRM(1), .FRMS_PER_MF(4)) i_ctsp_tx_port_f1 (
    .mclk, .reset_n, .subclass1(sc1), .tx_data, .sysref, .sync_req_n, .stream_clk_q(),
    .stream_reset_n_q(), .ready_q(ready2), .tx_marker_q(mk2), .lane_byte_q(), .lane_ctrl_q());
  ctsp_src_model #(.LANES(LN)) i_ctsp_src_model (.mclk, .stream_reset_n(s_rst_n), .ready, .tx_data);

  task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Markers lead the data by one cycle, so keep the value seen before each edge
  task automatic tick(input int k);
    repeat (k) begin
      pmk = mk;
      pmk2 = mk2;
      @(posedge mclk);
      #1;
    end
  endtask : tick

  task automatic wait_rdy(input logic which, input int bound);
    n = 0;
    while ((which ? ready2 : ready) !== 1'b1) begin
      if (n == bound) begin
        check(1, 0);
        finish_test();
      end
      seen |= (lb[7:0] === CHAR_MF_START) && (lc[0] === 1'b1);
      r2 |= ready2;
      tick(1);
      n++;
    end
  endtask : wait_rdy

  task automatic word(input logic [7:0] exp_mk);
    wait_rdy(1'b0, 8);
    check(pmk, exp_mk);
    w = tx_data;
    for (int b = 0; b < 4; b++) begin
      tick(1);
      check({ready, lc, lb}, {1'(b == 3), 2'b00, w[32+8*b +: 8], w[8*b +: 8]});
    end
  endtask : word

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    {reset_n, sync_req_n, sysref, seen, r2} = '0;
    sc1 = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    #1;
    check({s_rst_n, ready, mk, lb, lc}, 0);
    reset_n = 1'b1;
    tick(2);
    w[0] = s_clk;
    tick(1);
    check(s_clk, !w[0]);
    tick(20);
    check(s_rst_n, 1);
    check({ready, ready2, lc, lb}, {2'b00, 2'b11, {LN{CHAR_COMMA}}});
    $display("test reset_align done");
    sync_req_n = 1'b1;
    wait_rdy(1'b0, 80);
    check({seen, r2, n >= 4*4*2}, 3'b101);
    foreach (rows[i]) begin
      word(rows[i]);
    end
    $display("test data_words done");
    sysref = 1'b1;
    tick(2);
    sysref = 1'b0;
    wait_rdy(1'b1, 80);
    check(pmk2, 8'h1F);
    tick(4);
    check({ready2, pmk2}, 9'h11F);
    $display("test single_octet done");
    // Sync request passes a filter, so allow its latency before looking
    sync_req_n = 1'b0;
    tick(6);
    for (int i = 0; i < 8; i++) begin
      check({ready, ready2, lc, lb}, {2'b00, 2'b11, {LN{CHAR_COMMA}}});
      tick(1);
    end
    $display("test sync_drop done");
    finish_test();
  end
endmodule : tb_ctsp_tx_port
